// ==== obc_defines.svh ====
`ifndef OBC_DEFINES_SVH
`define OBC_DEFINES_SVH

// ==========================================================
// Register byte offsets
// ==========================================================
`define OBC_OFF_OPT0      12'h000
`define OBC_OFF_OPT1      12'h004
`define OBC_OFF_CTRL      12'h008
`define OBC_OFF_STAT      12'h00c
`define OBC_OFF_EEDATA    12'h010

// ==========================================================
// Option byte 0 field positions
// ==========================================================
`define OBC_B0_LOCK       0
`define OBC_B0_PINS       1

// ==========================================================
// Option byte 1 field positions
// ==========================================================
`define OBC_B1_WDSW       0
`define OBC_B1_WDHALT     1
`define OBC_B1_LVD_LO     2
`define OBC_B1_LVD_HI     3
`define OBC_B1_OSC_LO     4
`define OBC_B1_OSC_HI     6
`define OBC_B1_CSS        7

// ==========================================================
// Control and status bit positions
// ==========================================================
`define OBC_CTRL_PROG     0
`define OBC_STAT_PROG     0
`define OBC_STAT_ROM      1
`define OBC_STAT_LOCK     2
`define OBC_STAT_ERASE    3

// ==========================================================
// Reset, erase and response values
// ==========================================================
`define OBC_BLANK         8'hff
`define OBC_ERASED        8'h00
`define OBC_RSP_OKAY      2'b00
`define OBC_RSP_SLVERR    2'b10

`endif

// ==== obc_pkg.sv ====
package obc_pkg;

	// Main clock source encoding
	typedef enum logic [2:0] {
		OBC_CLK_HS  = 3'h0,
		OBC_CLK_MS  = 3'h1,
		OBC_CLK_MP  = 3'h2,
		OBC_CLK_LP  = 3'h3,
		OBC_CLK_XRC = 3'h4,
		OBC_CLK_XR1 = 3'h5,
		OBC_CLK_IRC = 3'h6,
		OBC_CLK_EXT = 3'h7
	} obc_clk_e;

	// Decoded static configuration
	typedef struct packed {
		logic       package_pin_select;
		logic       readout_lock;
		logic       clock_guard_disable;
		obc_clk_e   main_clock_source_sel;
		logic [1:0] supply_monitor_level;
		logic       halt_watchdog_reset;
		logic       watchdog_soft_enable;
	} obc_cfg_s;

	// Bus slave write FSM
	typedef enum logic [2:0] {
		OBC_W_IDLE = 3'b001,
		OBC_W_ACT  = 3'b010,
		OBC_W_RESP = 3'b100
	} obc_wst_e;

endpackage

// ==== obc_decode.sv ====
`timescale 1ns/100ps
`include "obc_defines.svh"

// Splits the two option bytes into named settings
module obc_decode (
	// Raw option bytes
	input  wire logic [7:0]        opt0,
	input  wire logic [7:0]        opt1,
	// Decoded fields
	output obc_pkg::obc_cfg_s      cfg
);

	// ==========================================================
	// Field decode
	// ==========================================================
	always_comb begin
		cfg.package_pin_select    = opt0[`OBC_B0_PINS];
		cfg.readout_lock          = opt0[`OBC_B0_LOCK];
		cfg.clock_guard_disable   = opt1[`OBC_B1_CSS];
		cfg.main_clock_source_sel = obc_pkg::obc_clk_e'(
			opt1[`OBC_B1_OSC_HI:`OBC_B1_OSC_LO]);
		cfg.supply_monitor_level  =
			opt1[`OBC_B1_LVD_HI:`OBC_B1_LVD_LO];
		cfg.halt_watchdog_reset   = opt1[`OBC_B1_WDHALT];
		cfg.watchdog_soft_enable  = opt1[`OBC_B1_WDSW];
	end

endmodule

// ==== obc_top.sv ====
// Summary of operation
// - Option bytes reachable only in programming mode
// - Unprogrammed option bytes read all ones
// - Mask-coded parts use fixed option values
// - Byte0 bit1 selects package pin count
// - Byte0 bit0 locks program memory read-out
// - Clearing lock erases memory and options
// - Lock never guards the data EEPROM
// - Byte1 bit7 disables clock security
// - Byte1 bits6:4 pick main clock source
// - Byte1 bits3:2 set supply monitor level
// - Byte1 bit1 resets on halt with watchdog
// - Byte1 bit0 zero forces watchdog always on
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "obc_defines.svh"

module obc_top #(
	parameter logic       ROM_PART = 1'b0,  // Mask-coded variant
	parameter logic [7:0] ROM_OPT0 = 8'hff, // Mask option byte 0
	parameter logic [7:0] ROM_OPT1 = 8'hff  // Mask option byte 1
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Static configuration
	output obc_pkg::obc_cfg_s cfg_q,
	// Program memory erase request
	output logic             mem_erase_q
);

	// ==========================================================
	// Storage
	// ==========================================================
	logic [7:0] opt0_q;           // Stored option byte 0
	logic [7:0] opt1_q;           // Stored option byte 1
	logic [7:0] eedata_q;         // Data EEPROM window byte
	logic       prog_q;           // Programming mode flag
	logic [7:0] eff0;             // Effective byte 0
	logic [7:0] eff1;             // Effective byte 1
	obc_pkg::obc_cfg_s cfg_d;     // Decoded effective options

	// Mask parts ignore the storage entirely
	assign eff0 = ROM_PART ? ROM_OPT0 : opt0_q;
	assign eff1 = ROM_PART ? ROM_OPT1 : opt1_q;

	obc_decode u_dec (
		.opt0 (eff0),
		.opt1 (eff1),
		.cfg  (cfg_d)
	);

	// ==========================================================
	// Write channel
	// ==========================================================
	obc_pkg::obc_wst_e wst_q;     // Write FSM state
	logic [11:0] awaddr_q;        // Latched write address
	logic        aw_have_q;       // Address taken
	logic [31:0] wdata_q;         // Latched write data
	logic [3:0]  wstrb_q;         // Latched strobes
	logic        w_have_q;        // Data taken
	logic        wr_ok;           // Address maps to a register
	logic        wr_go;           // Perform the write now

	assign wr_go = (wst_q == obc_pkg::OBC_W_ACT);

	// Address decode; option bytes only in programming mode
	always_comb begin
		unique case (awaddr_q)
			`OBC_OFF_OPT0,
			`OBC_OFF_OPT1:   wr_ok = prog_q && !ROM_PART;
			`OBC_OFF_CTRL,
			`OBC_OFF_EEDATA: wr_ok = 1'b1;
			default:         wr_ok = 1'b0;
		endcase
	end

	// Channel handshake and response sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wst_q         <= obc_pkg::OBC_W_IDLE;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= 12'h000;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `OBC_RSP_OKAY;
		end else begin
			unique case (wst_q)
				obc_pkg::OBC_W_IDLE: begin
					// Ready is raised only while the item is missing
					s_axi_awready <= !aw_have_q && !s_axi_awready;
					s_axi_wready  <= !w_have_q && !s_axi_wready;
					if (s_axi_awvalid && s_axi_awready) begin
						awaddr_q  <= s_axi_awaddr;
						aw_have_q <= 1'b1;
						s_axi_awready <= 1'b0;
					end
					if (s_axi_wvalid && s_axi_wready) begin
						wdata_q  <= s_axi_wdata;
						wstrb_q  <= s_axi_wstrb;
						w_have_q <= 1'b1;
						s_axi_wready <= 1'b0;
					end
					if (aw_have_q && w_have_q) begin
						wst_q         <= obc_pkg::OBC_W_ACT;
						s_axi_awready <= 1'b0;
						s_axi_wready  <= 1'b0;
					end
				end
				obc_pkg::OBC_W_ACT: begin
					s_axi_bvalid <= 1'b1;
					s_axi_bresp  <= wr_ok ? `OBC_RSP_OKAY
					                      : `OBC_RSP_SLVERR;
					wst_q        <= obc_pkg::OBC_W_RESP;
				end
				obc_pkg::OBC_W_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						aw_have_q    <= 1'b0;
						w_have_q     <= 1'b0;
						wst_q        <= obc_pkg::OBC_W_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Programming mode and data EEPROM window
	// ==========================================================
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prog_q   <= 1'b0;
			eedata_q <= `OBC_BLANK;
		end else if (wr_go && wstrb_q[0]) begin
			if (awaddr_q == `OBC_OFF_CTRL)
				prog_q <= wdata_q[`OBC_CTRL_PROG];
			if (awaddr_q == `OBC_OFF_EEDATA)
				eedata_q <= wdata_q[7:0];
		end
	end

	// ==========================================================
	// Option byte storage
	// ==========================================================
	// Non-volatile content survives the bus reset, so only a
	// blank (all ones) power-on value is modelled here.
	logic lock_clear;             // Lock bit goes from 1 to 0
	assign lock_clear = wr_go && wr_ok && wstrb_q[0]
	                    && awaddr_q == `OBC_OFF_OPT0
	                    && opt0_q[`OBC_B0_LOCK]
	                    && !wdata_q[`OBC_B0_LOCK];

	// Power-on value: without it the first reset would never
	// blank the storage and every option would stay unknown.
	logic init_q = 1'b0;          // Storage initialised
	always_ff @(posedge aclk) begin
		if (!aresetn && !init_q) begin
			opt0_q <= `OBC_BLANK;
			opt1_q <= `OBC_BLANK;
		end else if (lock_clear) begin
			opt0_q <= `OBC_ERASED;
			opt1_q <= `OBC_ERASED;
		end else if (wr_go && wr_ok && wstrb_q[0]) begin
			// Programmer sets each byte itself
			if (awaddr_q == `OBC_OFF_OPT0)
				opt0_q <= wdata_q[7:0];
			if (awaddr_q == `OBC_OFF_OPT1)
				opt1_q <= wdata_q[7:0];
		end
	end

	// First reset marks storage as initialised
	always_ff @(posedge aclk) begin
		if (!aresetn)
			init_q <= 1'b1;
		else
			init_q <= init_q;
	end

	// Erase pulse toward the program memory
	always_ff @(posedge aclk) begin
		if (!aresetn)
			mem_erase_q <= 1'b0;
		else
			mem_erase_q <= lock_clear;
	end

	// ==========================================================
	// Static configuration load
	// ==========================================================
	// Taken only while reset is low so that programming changes
	// never disturb a running device.
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cfg_q <= cfg_d;
	end

	// ==========================================================
	// Read channel
	// ==========================================================
	logic [31:0] rd_val;          // Selected read word
	logic        rd_ok;           // Address maps to a register

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok  = 1'b1;
		unique case (s_axi_araddr)
			`OBC_OFF_OPT0: begin
				rd_ok  = prog_q;
				rd_val = {24'h000000, eff0};
			end
			`OBC_OFF_OPT1: begin
				rd_ok  = prog_q;
				rd_val = {24'h000000, eff1};
			end
			`OBC_OFF_CTRL: rd_val[`OBC_CTRL_PROG] = prog_q;
			`OBC_OFF_STAT: begin
				rd_val[`OBC_STAT_PROG]  = prog_q;
				rd_val[`OBC_STAT_ROM]   = ROM_PART;
				rd_val[`OBC_STAT_LOCK]  = cfg_q.readout_lock;
				rd_val[`OBC_STAT_ERASE] = mem_erase_q;
			end
			// Readable whatever the lock says
			`OBC_OFF_EEDATA: rd_val = {24'h000000, eedata_q};
			default: rd_ok = 1'b0;
		endcase
	end

	// One read at a time, answered the cycle after acceptance
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `OBC_RSP_OKAY;
		end else if (s_axi_rvalid) begin
			s_axi_arready <= 1'b0;
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_ok ? rd_val : 32'h0000_0000;
			s_axi_rresp   <= rd_ok ? `OBC_RSP_OKAY
			                       : `OBC_RSP_SLVERR;
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	chk_cfg_static: assert property (@(posedge aclk)
		aresetn && $past(aresetn) |-> $stable(cfg_q))
		else $error("configuration changed outside reset");

	chk_erase_zero: assert property (@(posedge aclk)
		disable iff (!aresetn)
		lock_clear |=> opt0_q == 8'h00 && opt1_q == 8'h00
		               && mem_erase_q)
		else $error("lock clear did not erase");

	chk_opt_gated: assert property (@(posedge aclk)
		disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && !prog_q
		&& s_axi_araddr == `OBC_OFF_OPT0
		|=> s_axi_rvalid && s_axi_rresp == `OBC_RSP_SLVERR)
		else $error("option byte read outside programming mode");

	chk_rom_fixed: assert property (@(posedge aclk)
		ROM_PART |-> eff0 == ROM_OPT0 && eff1 == ROM_OPT1)
		else $error("mask part options not fixed");

	chk_ee_open: assert property (@(posedge aclk)
		disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == `OBC_OFF_EEDATA
		|=> s_axi_rresp == `OBC_RSP_OKAY
		    && s_axi_rdata[7:0] == $past(eedata_q))
		else $error("data EEPROM read refused");

	// First reset edge skipped: storage is still unknown there
	chk_lock_map: assert property (@(posedge aclk)
		!aresetn && $past(!aresetn)
		|=> cfg_q.readout_lock == $past(eff0[0]))
		else $error("lock bit mis-decoded");

	chk_osc_map: assert property (@(posedge aclk)
		!aresetn && $past(!aresetn)
		|=> cfg_q.main_clock_source_sel == $past(eff1[6:4]))
		else $error("clock source mis-decoded");

	chk_wd_map: assert property (@(posedge aclk)
		!aresetn && $past(!aresetn)
		|=> cfg_q.watchdog_soft_enable == $past(eff1[0])
		             && cfg_q.halt_watchdog_reset == $past(eff1[1]))
		else $error("watchdog bits mis-decoded");

endmodule

// ==== obc_prog_tool.sv ====
`timescale 1ns/100ps

// =====
// External programmer: AXI4-Lite master
// =====
// Every change after time zero lands by non-blocking assignment just after a rising edge,
// so the slave never sees a request move under its sampling edge.
module obc_prog_tool (
	// Clock
	input  wire logic        aclk,
	// Write address
	output logic [11:0]      awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	// Write data
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	input  wire logic        wready,
	// Write response
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output logic             bready,
	// Read address
	output logic [11:0]      araddr,
	output logic             arvalid,
	input  wire logic        arready,
	// Read data
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);

	// Idle bus at time zero
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// Full byte written each time; the tool owns every option bit
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Release each channel at the edge that takes it
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw_ok = 1'b1;
			end
			if (!w_ok && wready === 1'b1) begin
				wvalid <= 1'b0;
				w_ok = 1'b1;
			end
		end
		// No latency assumed; the bench timeout ends a hang
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		// One idle edge, so a following call never re-drives now
		@(posedge aclk);
	endtask

	// Single read, rready held until the data arrives
	task automatic rd(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		// One idle edge, so a following call never re-drives now
		@(posedge aclk);
	endtask

endmodule

// ==== obc_tb.sv ====
`timescale 1ns/100ps
`include "obc_defines.svh"

module tb;
	localparam logic [1:0] OK  = `OBC_RSP_OKAY;
	localparam logic [1:0] ERR = `OBC_RSP_SLVERR;
	localparam logic [7:0] ROM0 = 8'hfd;  // Mask byte 0, arbitrary
	localparam logic [7:0] ROM1 = 8'h5a;  // Mask byte 1, arbitrary

	// Bus and design nets
	logic              aclk, aresetn;
	logic [11:0]       awaddr, araddr;
	logic [31:0]       wdata, rdata, rv, rnd;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, rsp;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready, mem_erase_q;
	obc_pkg::obc_cfg_s cfg_q, cfg_exp, cfg_rom;
	logic [7:0]        o0, o1;
	integer            seed, miscompares, checked, erases, cyc, i;

	// =====
	// Clock, design and programmer
	// =====
	initial aclk = 1'b0;
	always #25 aclk = ~aclk;

	obc_top u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .cfg_q(cfg_q),
		.mem_erase_q(mem_erase_q)
	);

	// Mask-coded part with an idle bus: options come from the mask
	obc_top #(.ROM_PART(1'b1), .ROM_OPT0(ROM0), .ROM_OPT1(ROM1)) u_rom (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(12'h000), .s_axi_awvalid(1'b0),
		.s_axi_awready(), .s_axi_wdata(32'h0000_0000),
		.s_axi_wstrb(4'h0), .s_axi_wvalid(1'b0),
		.s_axi_wready(), .s_axi_bresp(),
		.s_axi_bvalid(), .s_axi_bready(1'b0),
		.s_axi_araddr(12'h000), .s_axi_arvalid(1'b0),
		.s_axi_arready(), .s_axi_rdata(),
		.s_axi_rresp(), .s_axi_rvalid(),
		.s_axi_rready(1'b0), .cfg_q(cfg_rom),
		.mem_erase_q()
	);

	obc_prog_tool u_tool (
		.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready)
	);

	// Erase pulses seen; a stuck pulse shows as an excess count
	always @(posedge aclk) begin
		if (mem_erase_q === 1'b1) begin
			erases++;
		end
	end

	// =====
	// Helpers
	// =====
	// Expected settings: byte1 maps bit for bit onto the low fields
	function automatic obc_pkg::obc_cfg_s exp_cfg(input logic [7:0] b0,
		input logic [7:0] b1);
		exp_cfg = obc_pkg::obc_cfg_s'({b0[1], b0[0], b1});
	endfunction

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wchk(input string n, input logic [11:0] a,
		input logic [31:0] d, input logic [1:0] er);
		u_tool.wr(a, d, rsp);
		chk(n, {30'h0, er}, {30'h0, rsp});
	endtask

	task automatic rchk(input string n, input logic [11:0] a,
		input logic [31:0] ed, input logic [1:0] er);
		u_tool.rd(a, rv, rsp);
		chk(n, ed, rv);
		chk(n, {30'h0, er}, {30'h0, rsp});
	endtask

	// Reset for n edges; storage is nonvolatile across later resets
	task automatic rst(input int n);
		aresetn <= 1'b0;
		repeat (n) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			results;
		end
	end

	// =====
	// Tests
	// =====
	initial begin
		seed = 53;
		{miscompares, checked, erases, cyc} = '0;
		aresetn = 1'b0;
		rst(12);
		// Blank part, programming mode still off
		chk("cfg_blank", 32'h3ff, {22'h0, cfg_q});
		cfg_exp = exp_cfg(ROM0, ROM1);
		chk("cfg_rom", {22'h0, cfg_exp}, {22'h0, cfg_rom});
		rchk("opt0_closed", `OBC_OFF_OPT0, 32'h0, ERR);
		wchk("opt1_closed", `OBC_OFF_OPT1, 32'h0, ERR);
		rchk("unmapped_rd", 12'h100, 32'h0, ERR);
		wchk("unmapped_wr", 12'h200, 32'h0, ERR);
		wchk("prog_on", `OBC_OFF_CTRL, 32'h1, OK);
		// Status: programming mode on, flash part, lock loaded set
		rchk("stat", `OBC_OFF_STAT, 32'h5, OK);
		rchk("opt0_blank", `OBC_OFF_OPT0, 32'hff, OK);
		rchk("opt1_blank", `OBC_OFF_OPT1, 32'hff, OK);
		$display("test blank done");
		// Every clock and monitor code, lock kept set throughout
		cfg_exp = obc_pkg::obc_cfg_s'(10'h3ff);
		for (i = 0; i < 8; i++) begin
			rnd = $random(seed);
			o0 = {6'h3f, rnd[8], 1'b1};
			o1 = {rnd[7], i[2:0], i[1:0], rnd[1:0]};
			// Data EEPROM stays open under the lock
			wchk("ee_wr", `OBC_OFF_EEDATA, rnd, OK);
			rchk("ee_rd", `OBC_OFF_EEDATA, {24'h0, rnd[7:0]}, OK);
			wchk("prog_on", `OBC_OFF_CTRL, 32'h1, OK);
			wchk("opt0_wr", `OBC_OFF_OPT0, {24'h0, o0}, OK);
			wchk("opt1_wr", `OBC_OFF_OPT1, {24'h0, o1}, OK);
			rchk("opt1_rd", `OBC_OFF_OPT1, {24'h0, o1}, OK);
			// New bytes must not reach the outputs before a reset
			chk("cfg_hold", {22'h0, cfg_exp}, {22'h0, cfg_q});
			rst(3);
			cfg_exp = exp_cfg(o0, o1);
			chk("cfg_decode", {22'h0, cfg_exp}, {22'h0, cfg_q});
		end
		$display("test decode done");
		// Lock clear erases both bytes, once only
		chk("no_erase_yet", 32'h0, erases);
		wchk("prog_on", `OBC_OFF_CTRL, 32'h1, OK);
		wchk("unlock", `OBC_OFF_OPT0, 32'hfe, OK);
		chk("erase_pulse", 32'h1, erases);
		rchk("opt0_erased", `OBC_OFF_OPT0, 32'h0, OK);
		rchk("opt1_erased", `OBC_OFF_OPT1, 32'h0, OK);
		wchk("clear_again", `OBC_OFF_OPT0, 32'h0, OK);
		chk("erase_once", 32'h1, erases);
		rst(3);
		chk("cfg_erased", 32'h0, {22'h0, cfg_q});
		$display("test erase done");
		results;
	end

endmodule
